// *** rtl/dtp_pkg.sv ***
package dtp_pkg;

   // ==========================================
   // widths
   localparam int ADDR_W = 18;
   localparam int DATA_W = 32;
   localparam int LANE_W = 4;
   localparam int SIZE_W = 4;

   // ==========================================
   // access size encodings on the core side
   typedef enum logic [1:0]
   {
      DTP_SZ_BYTE = 2'b00,
      DTP_SZ_HALF = 2'b01,
      DTP_SZ_WORD = 2'b10
   } dtp_size_e;

   // memory size configuration codes
   localparam logic [SIZE_W-1:0] SIZE_ABSENT = 4'h0;
   localparam logic [SIZE_W-1:0] SIZE_MIN = 4'h3;
   localparam logic [SIZE_W-1:0] SIZE_MAX = 4'hb;

   // ==========================================
   // reset values and other constants
   localparam logic [ADDR_W-1:0] ADDR_RST = 18'h0_0000;
   localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
   localparam logic [LANE_W-1:0] LANES_NONE = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_STEP = 18'h0_0001;
   localparam logic [1:0] HALF_HI = 2'h2;

   // ==========================================
   // core request bundle
   typedef struct packed
   {
      logic [ADDR_W+1:0] byte_addr; // byte address from the core
      logic write; // 1 = write
      dtp_size_e size; // access width
      logic [DATA_W-1:0] wdata; // write data, lane aligned
   } dtp_req_s;

   // memory side request bundle
   typedef struct packed
   {
      logic [ADDR_W-1:0] addr;
      logic write;
      logic [LANE_W-1:0] lanes;
      logic [DATA_W-1:0] wdata;
   } dtp_mem_s;

   // ==========================================
   // lane strobes from low address bits and size
   function automatic logic [LANE_W-1:0] lane_mask(input logic [1:0] lo, input dtp_size_e sz);
      logic [LANE_W-1:0] m;
      m = LANES_NONE;
      case (sz)
         DTP_SZ_BYTE: m = 4'h1 << lo;
         DTP_SZ_HALF: m = (lo[1] == 1'b1) ? 4'hc : 4'h3;
         DTP_SZ_WORD: m = 4'hf;
         default: m = LANES_NONE;
      endcase
      return m;
   endfunction : lane_mask

endpackage : dtp_pkg

// *** rtl/dtp_seq_track.sv ***
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// remembers last request word address, flags follow-on
module dtp_seq_track
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic req_take, // a new request is accepted
   input wire logic [dtp_pkg::ADDR_W-1:0] req_addr,
   output logic seq_hit
);

   logic [dtp_pkg::ADDR_W-1:0] last_addr_reg; // previous request address
   logic last_valid_reg; // no history right after reset

   // ==========================================
   // capture history on each accepted request
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         last_addr_reg <= dtp_pkg::ADDR_RST;
         last_valid_reg <= 1'b0;
      end
      else if (req_take)
      begin
         last_addr_reg <= req_addr;
         last_valid_reg <= 1'b1;
      end
   end

   // follow-on compare, combinational for the next-value path
   assign seq_hit = last_valid_reg && (req_addr == last_addr_reg + dtp_pkg::ADDR_STEP);

endmodule : dtp_seq_track

`default_nettype wire

// *** rtl/dtp_port.sv ***
`timescale 1ns/1ps
`default_nettype none

// Operation
// - eighteen-bit word address out every cycle, last address held between requests
// - select high in the same cycle as the access
// - dma enable routes dma address to memory
// - dma select ORed with own select while dma enable is high
// - idle low on access, high otherwise
// - direction zero read, one write
// - sequential flags address following previous request
// - sequential held high during wait cycles
// - byte lanes zero for reads, size-based writes
// - write data driven and held while waited

module dtp_port
(
   input wire logic clock,
   input wire logic rst_n,
   // core side
   input wire logic core_req_valid, // core has an access for next cycle
   input wire dtp_pkg::dtp_req_s core_req,
   output logic core_req_ready, // request taken this edge
   output logic core_rdata_valid,
   output logic [dtp_pkg::DATA_W-1:0] core_rdata,
   output logic mem_present, // size code is a legal, nonzero size
   // memory side
   output logic [dtp_pkg::ADDR_W-1:0] dmem_word_addr,
   output logic dmem_select,
   output logic dmem_idle,
   output logic dmem_write_not_read,
   output logic dmem_sequential,
   output logic [dtp_pkg::LANE_W-1:0] dmem_byte_lanes,
   output logic [dtp_pkg::DATA_W-1:0] dmem_write_data,
   input wire logic [dtp_pkg::DATA_W-1:0] dmem_read_data,
   input wire logic dmem_stall,
   input wire logic [dtp_pkg::SIZE_W-1:0] dmem_size_cfg,
   // dma agent
   input wire logic dmem_dma_enable,
   input wire logic [dtp_pkg::ADDR_W-1:0] dmem_dma_addr,
   input wire logic dmem_dma_select
);

   // ==========================================
   // port states
   typedef enum logic [1:0]
   {
      DTP_IDLE = 2'b00, // no request on the memory
      DTP_REQ = 2'b01, // request cycle
      DTP_WAIT = 2'b10 // memory stalled the request
   } dtp_state_e;

   dtp_state_e state_reg; // current cycle type
   dtp_state_e state_next;
   dtp_pkg::dtp_mem_s req_reg; // own request held on the memory
   dtp_pkg::dtp_mem_s req_next;
   logic own_sel_next; // own select for the coming cycle
   logic seq_hit; // next address follows the last request
   logic seq_reg; // sequential flag of the held request
   logic rd_pending_reg; // outstanding read awaiting data
   logic [dtp_pkg::ADDR_W-1:0] mem_addr_next;
   logic in_req; // current cycle is a request or wait cycle
   logic accept; // a new core access is launched
   logic size_ok;

   // ==========================================
   // memory presence decode; static tie, reserved codes count as absent
   assign size_ok = (dmem_size_cfg >= dtp_pkg::SIZE_MIN) && (dmem_size_cfg <= dtp_pkg::SIZE_MAX);

   // stall only counts inside request and wait cycles
   assign in_req = (state_reg == DTP_REQ) || (state_reg == DTP_WAIT);

   // a new access may launch unless the held one is still stalled
   assign accept = core_req_valid && size_ok && !(in_req && dmem_stall);

   // ==========================================
   // request payload for the next cycle
   always_comb
   begin
      req_next = req_reg;
      if (accept)
      begin
         req_next.addr = core_req.byte_addr[dtp_pkg::ADDR_W+1:2];
         req_next.write = core_req.write;
         // reads carry no lanes at all
         req_next.lanes = core_req.write ?
            dtp_pkg::lane_mask(core_req.byte_addr[1:0], core_req.size) :
            dtp_pkg::LANES_NONE;
         req_next.wdata = core_req.wdata;
      end
   end

   // ==========================================
   // cycle type sequencing
   always_comb
   begin
      state_next = DTP_IDLE;
      case (state_reg)
         DTP_IDLE: state_next = accept ? DTP_REQ : DTP_IDLE;
         DTP_REQ, DTP_WAIT:
         begin
            if (dmem_stall)
               state_next = DTP_WAIT; // held, payload unchanged
            else
               state_next = accept ? DTP_REQ : DTP_IDLE;
         end
         default: state_next = DTP_IDLE;
      endcase
   end

   // own select announces the coming access; dma select joins it
   assign own_sel_next = accept;
   // dma address overrides the own address on the memory
   assign mem_addr_next = dmem_dma_enable ? dmem_dma_addr : req_next.addr;

   // ==========================================
   // state and held request
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         state_reg <= DTP_IDLE;
         req_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
         req_reg <= req_next; // kept while stalled
      end
   end

   // ==========================================
   // sequential history
   dtp_seq_track u_seq
   (
      .clock(clock),
      .rst_n(rst_n),
      .req_take(accept),
      .req_addr(req_next.addr),
      .seq_hit(seq_hit)
   );

   // sequential flag: forced high across waits
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         seq_reg <= 1'b0;
      else if (in_req && dmem_stall)
         seq_reg <= 1'b1;
      else if (accept)
         seq_reg <= seq_hit;
      else
         seq_reg <= 1'b0;
   end

   // ==========================================
   // memory outputs, all registered
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         dmem_word_addr <= dtp_pkg::ADDR_RST;
         dmem_select <= 1'b0;
         dmem_idle <= 1'b1;
         dmem_write_not_read <= 1'b0;
         dmem_byte_lanes <= dtp_pkg::LANES_NONE;
         dmem_write_data <= dtp_pkg::DATA_RST;
      end
      else
      begin
         dmem_word_addr <= mem_addr_next;
         // select is registered on the same edge as the access
         dmem_select <= own_sel_next || (dmem_dma_enable && dmem_dma_select);
         // idle low only when an own access is on the memory
         dmem_idle <= !(state_next != DTP_IDLE && size_ok);
         dmem_write_not_read <= req_next.write;
         dmem_byte_lanes <= req_next.lanes;
         dmem_write_data <= req_next.wdata;
      end
   end

   assign dmem_sequential = seq_reg;

   // ==========================================
   // read data capture; only unwaited data cycles are sampled
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         rd_pending_reg <= 1'b0;
         core_rdata_valid <= 1'b0;
         core_rdata <= dtp_pkg::DATA_RST;
      end
      else
      begin
         rd_pending_reg <= in_req && !req_reg.write;
         core_rdata_valid <= 1'b0;
         if (in_req && !req_reg.write && !dmem_stall)
         begin
            core_rdata_valid <= 1'b1;
            core_rdata <= dmem_read_data;
         end
      end
   end

   // ==========================================
   // core handshake and presence status
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         core_req_ready <= 1'b0;
         mem_present <= 1'b0;
      end
      else
      begin
         core_req_ready <= accept;
         mem_present <= size_ok;
      end
   end

endmodule : dtp_port

`default_nettype wire

// *** testbench/dtp_port_props.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========
// port checks, clock domain of the port
module dtp_port_props
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic core_req_ready,
   input wire logic core_rdata_valid,
   input wire logic [31:0] core_rdata,
   input wire logic [17:0] dmem_word_addr,
   input wire logic dmem_select,
   input wire logic dmem_idle,
   input wire logic dmem_write_not_read,
   input wire logic dmem_sequential,
   input wire logic [3:0] dmem_byte_lanes,
   input wire logic [31:0] dmem_write_data,
   input wire logic [31:0] dmem_read_data,
   input wire logic dmem_stall,
   input wire logic [3:0] dmem_size_cfg,
   input wire logic dmem_dma_enable,
   input wire logic [17:0] dmem_dma_addr,
   input wire logic dmem_dma_select
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   a_read_lanes: assert property (!dmem_idle && !dmem_write_not_read |-> dmem_byte_lanes == 4'h0)
      else $error("lanes set on read");
   a_stall_hold: assert property (!dmem_idle && dmem_stall && !dmem_dma_enable |=>
      $stable(dmem_word_addr) && $stable(dmem_write_data) && $stable(dmem_byte_lanes)
      && $stable(dmem_write_not_read))
      else $error("request moved while waited");
   a_wait_seq: assert property (!dmem_idle && dmem_stall |=> dmem_sequential)
      else $error("sequential low in wait");
   a_dma_addr: assert property (dmem_dma_enable |=> dmem_word_addr == $past(dmem_dma_addr))
      else $error("dma address not routed");
   a_dma_sel: assert property (dmem_dma_enable && dmem_dma_select |=> dmem_select)
      else $error("dma select lost");
   a_ready_req: assert property (core_req_ready |-> !dmem_idle && dmem_select)
      else $error("request cycle not shown");
   a_read_data: assert property (!dmem_idle && !dmem_stall && !dmem_write_not_read |=>
      core_rdata_valid && core_rdata == $past(dmem_read_data))
      else $error("read data not returned");
   a_write_nodata: assert property (!dmem_idle && !dmem_stall && dmem_write_not_read |=>
      !core_rdata_valid)
      else $error("read data on write");
   a_absent_idle: assert property (dmem_size_cfg == 4'h0 [*3] |-> dmem_idle && !core_req_ready)
      else $error("access with no memory");
endmodule : dtp_port_props

bind dtp_port dtp_port_props props
(
   .clock, .rst_n, .core_req_ready, .core_rdata_valid, .core_rdata, .dmem_word_addr,
   .dmem_select, .dmem_idle, .dmem_write_not_read, .dmem_sequential, .dmem_byte_lanes,
   .dmem_write_data, .dmem_read_data, .dmem_stall, .dmem_size_cfg, .dmem_dma_enable,
   .dmem_dma_addr, .dmem_dma_select
);
`default_nettype wire

// *** testbench/dtp_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========
// small data sram behind the port
module dtp_mem_model
(
   input wire logic clock,
   input wire logic hold_req, // bench asks for wait cycles
   input wire logic dmem_idle,
   input wire logic [17:0] dmem_word_addr,
   input wire logic dmem_write_not_read,
   input wire logic [3:0] dmem_byte_lanes,
   input wire logic [31:0] dmem_write_data,
   output logic [31:0] dmem_read_data,
   output logic dmem_stall
);
   logic [31:0] mem [64]; // only low address bits decoded
   logic [31:0] last_rd = 32'h0; // last word put on the bus
   initial
      for (int i = 0; i < 64; i++)
         mem[i] = 32'h5a5a_0000 + i;
   // stall only in request or wait cycles
   assign dmem_stall = !dmem_idle && hold_req;
   // released bus shows the inverse, never a stale word
   assign dmem_read_data = !dmem_idle ? mem[dmem_word_addr[5:0]] : ~last_rd;
   // writes land only in unwaited cycles
   always @(posedge clock)
   begin
      if (!dmem_idle)
         last_rd <= mem[dmem_word_addr[5:0]];
      for (int b = 0; b < 4; b++)
         if (!dmem_idle && !dmem_stall && dmem_write_not_read && dmem_byte_lanes[b])
            mem[dmem_word_addr[5:0]][8*b+:8] <= dmem_write_data[8*b+:8];
   end
endmodule : dtp_mem_model
`default_nettype wire

// *** testbench/dtp_port_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========
// bench for the data memory port
module dtp_port_tb;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic core_req_valid = 1'b0;
   dtp_pkg::dtp_req_s core_req = '0;
   logic hold_req = 1'b0; // wait cycles from the model
   logic [3:0] size_cfg = 4'h3;
   logic dma_en = 1'b0;
   logic dma_sel = 1'b0;
   logic [17:0] dma_addr = 18'h0;
   logic rdy, rv, pres, sel, idle, nrw, seq, stall;
   logic [31:0] rdata, wd, rd;
   logic [17:0] addr;
   logic [3:0] lanes;
   int err_count = 0;
   int total_checks = 0;
   dtp_pkg::dtp_req_s rq [5]; // back to back requests
   logic [3:0] el [5];
   logic es [5];
   logic [31:0] erd [5];
   always #2 clock = ~clock;
   dtp_port dut
   (
      .clock, .rst_n, .core_req_valid, .core_req, .core_req_ready(rdy),
      .core_rdata_valid(rv), .core_rdata(rdata), .mem_present(pres), .dmem_word_addr(addr),
      .dmem_select(sel), .dmem_idle(idle), .dmem_write_not_read(nrw), .dmem_sequential(seq),
      .dmem_byte_lanes(lanes), .dmem_write_data(wd), .dmem_read_data(rd), .dmem_stall(stall),
      .dmem_size_cfg(size_cfg), .dmem_dma_enable(dma_en), .dmem_dma_addr(dma_addr),
      .dmem_dma_select(dma_sel)
   );
   dtp_mem_model mem
   (
      .clock, .hold_req, .dmem_idle(idle), .dmem_word_addr(addr), .dmem_write_not_read(nrw),
      .dmem_byte_lanes(lanes), .dmem_write_data(wd), .dmem_read_data(rd), .dmem_stall(stall)
   );
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e)
      begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : report_and_stop
   // every size code, then refusal with no memory
   task automatic t_size;
      for (int c = 0; c < 17; c++)
      begin
         @(posedge clock);
         size_cfg <= (c < 16) ? 4'(c) : 4'h0;
         core_req_valid <= (c == 16);
         core_req <= rq[0];
         repeat (3) @(posedge clock);
         #1 chk("present", pres, 32'(c > 2 && c < 12));
         chk("refused", rdy, 0);
      end
      // restore a legal size on an edge; valid drops on the same edge
      @(posedge clock);
      size_cfg <= 4'h3;
      core_req_valid <= 1'b0;
      repeat (2) @(posedge clock);
   endtask : t_size
   // pipelined writes then reads
   task automatic t_burst;
      for (int i = 0; i < 7; i++)
      begin
         @(posedge clock);
         core_req_valid <= (i < 5);
         if (i < 5)
            core_req <= rq[i];
         #1;
         if (i > 0 && i < 6)
         begin
            chk("idle", idle + 2 * rdy, 2);
            chk("addr", addr, 32'(rq[i-1].byte_addr >> 2));
            chk("dir", nrw, rq[i-1].write);
            chk("lanes", lanes, el[i-1]);
            chk("seq", seq, es[i-1]);
            if (rq[i-1].write)
               chk("wdata", wd, rq[i-1].wdata);
         end
         if (i > 1)
            chk("rdata", rv ? rdata : 32'h0, erd[i-2]);
      end
   endtask : t_burst
   // one stalled read, then dma takeover
   task automatic t_stall;
      @(posedge clock);
      core_req_valid <= 1'b1;
      core_req <= '{20'h0_0020, 1'b0, dtp_pkg::DTP_SZ_WORD, 32'h0};
      hold_req <= 1'b1;
      @(posedge clock);
      core_req_valid <= 1'b0;
      #1 chk("stall addr", addr, 32'h8);
      @(posedge clock);
      hold_req <= 1'b0;
      #1 chk("wait addr", addr, 32'h8);
      chk("wait seq", seq, 1);
      chk("wait rv", rv, 0);
      @(posedge clock);
      // dma inputs change on the edge, never off it
      dma_en <= 1'b1;
      dma_sel <= 1'b1;
      dma_addr <= 18'h2_abcd;
      #1 chk("late rdata", rdata, 32'h5a5a_0008);
      chk("late rv", rv, 1);
      @(posedge clock);
      dma_en <= 1'b0;
      dma_sel <= 1'b0;
      #1 chk("dma addr", addr, 32'h0002_abcd);
      chk("dma sel", sel, 1);
      // stalled halfword write: data, lanes and direction hold through the wait
      @(posedge clock);
      core_req_valid <= 1'b1;
      core_req <= '{20'h0_0024, 1'b1, dtp_pkg::DTP_SZ_HALF, 32'h0000_c0de};
      hold_req <= 1'b1;
      @(posedge clock);
      core_req_valid <= 1'b0;
      #1 chk("wr lanes", lanes, 32'h3);
      @(posedge clock);
      hold_req <= 1'b0;
      #1 chk("wait wdata", wd, 32'h0000_c0de);
      chk("wait lanes", lanes, 32'h3);
      chk("wait dir", nrw, 1);
      // let the checker see the cycles after the last request
      repeat (2) @(posedge clock);
   endtask : t_stall
   initial
   begin
      rq = '{'{20'h0_0010, 1'b1, dtp_pkg::DTP_SZ_WORD, 32'h1122_3344},
             '{20'h0_0016, 1'b1, dtp_pkg::DTP_SZ_BYTE, 32'h00ab_0000},
             '{20'h0_001a, 1'b1, dtp_pkg::DTP_SZ_HALF, 32'hbeef_0000},
             '{20'h0_0010, 1'b0, dtp_pkg::DTP_SZ_WORD, 32'h0},
             '{20'h0_0014, 1'b0, dtp_pkg::DTP_SZ_WORD, 32'h0}};
      el = '{4'hf, 4'h4, 4'hc, 4'h0, 4'h0};
      es = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
      erd = '{32'h0, 32'h0, 32'h0, 32'h1122_3344, 32'h5aab_0005};
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      t_size();
      t_burst();
      t_stall();
      report_and_stop();
   end
endmodule : dtp_port_tb
`default_nettype wire
